// file: rtl/tacav_regs.vh
// Purpose: Constants for the temperature converter averaging control
// Assumes: CORE_CLK at 125 MHz
// Notes:   Times are given in their own unit, cycle counts derived from them
`ifndef TACAV_REGS_VH
`define TACAV_REGS_VH
// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define TACAV_RES_W        11
`define TACAV_AVG_N        32
`define TACAV_AVG_LOG2     5
`define TACAV_ACC_W        16
`define TACAV_HI_W         8
`define TACAV_LO_W         3
// ----------------------------------------------------------------
// Channel and read selects
// ----------------------------------------------------------------
`define TACAV_CH_LOCAL     1'b0
`define TACAV_CH_REMOTE    1'b1
`define TACAV_RD_LOW       2'h0
`define TACAV_RD_LOC_HIGH  2'h1
`define TACAV_RD_REM_HIGH  2'h2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TACAV_CLK_MHZ      125
`define TACAV_T_POR_NS     1500000
`define TACAV_POR_CYC      ((`TACAV_T_POR_NS * `TACAV_CLK_MHZ) / 1000)
`define TACAV_RST_VAL      8'h00
`endif

// file: rtl/tacav_avg.v
// Purpose: Sums a fixed number of raw samples and yields their mean
// Assumes: Samples are 11-bit two's complement, one per valid strobe
// Notes:   Mean by arithmetic shift, truncating toward minus infinity
`timescale 1ns/1ps
`include "tacav_regs.vh"
module tacav_avg (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire                    ce,
    input  wire                    clear,
    input  wire                    smp_valid,
    input  wire [`TACAV_RES_W-1:0] smp_data,
    output reg                     done_q,
    output reg  [`TACAV_RES_W-1:0] mean_q
);
    reg  [`TACAV_ACC_W-1:0]    acc_q;
    reg  [`TACAV_AVG_LOG2-1:0] cnt_q;
    wire [`TACAV_ACC_W-1:0]    smp_ext;
    wire [`TACAV_ACC_W-1:0]    sum;

    assign smp_ext = {{(`TACAV_ACC_W-`TACAV_RES_W){smp_data[`TACAV_RES_W-1]}}, smp_data};
    assign sum     = acc_q + smp_ext;

    // ----------------------------------------------------------------
    // Accumulate 32 samples
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q  <= 16'h0000;
            cnt_q  <= 5'h00;
            done_q <= 1'b0;
            mean_q <= 11'h000;
        end else if (ce) begin
            done_q <= 1'b0;
            if (clear) begin
                acc_q <= 16'h0000;
                cnt_q <= 5'h00;
            end else if (smp_valid) begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == 5'h1f) begin
                    acc_q  <= 16'h0000;
                    done_q <= 1'b1;
                    mean_q <= sum[`TACAV_ACC_W-1:`TACAV_AVG_LOG2];
                end else begin
                    acc_q <= sum;
                end
            end
        end
    end
endmodule // tacav_avg

// file: rtl/tacav_top.v
// Purpose: Runs, averages and stores local and remote temperature results
// Assumes: Raw ADC samples come from logic on CORE_CLK; bus reads from the
//          serial slave on the same clock
// Notes:   Reads are one-cycle strobes; data is answered one cycle later
//
// Contract
// - Each result is an 11-bit value taken from the on-chip converter.
// - Each stored result is the average of 32 consecutive raw measurements.
// - The newest averaged result, two's complement, goes to the low and high byte pair.
// - Conversions halt while the run bit is 0 and run continuously while it is 1.
// - After power-on or soft reset the block is ready after 1.5 ms of clocks with CE high and ignores reads until then.
// - Local and remote channels each keep their own result storage.
// - The eight top result bits go to the high byte and the three low bits to the low byte.
// - A low-byte read freezes all result registers until the remote high byte is read.
`timescale 1ns/1ps
`include "tacav_regs.vh"
module tacav_top #(
    parameter [27:0] POR_CYCLES = `TACAV_POR_CYC
) (
    input  wire                    CORE_CLK,
    input  wire                    RST_N,
    input  wire                    CE,
    input  wire                    RUN,
    input  wire                    SOFT_RESET,
    input  wire                    ADC_VALID,
    input  wire [`TACAV_RES_W-1:0] ADC_DATA,
    input  wire                    RD_STB,
    input  wire [1:0]              RD_SEL,
    output reg                     ADC_START,
    output reg                     ADC_CHANNEL,
    output reg                     READY,
    output reg                     RD_ACK,
    output reg  [7:0]              RD_DATA,
    output reg                     FROZEN,
    output reg                     LOCAL_UPDATE,
    output reg                     REMOTE_UPDATE
);
    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    localparam [3:0] ST_BOOT = 4'h1;
    localparam [3:0] ST_IDLE = 4'h2;
    localparam [3:0] ST_REQ  = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    reg  [3:0]              st_q;
    reg  [3:0]              st_d;
    reg  [27:0]             por_cnt_q;
    reg  [`TACAV_RES_W-1:0] loc_res_q;
    reg  [`TACAV_RES_W-1:0] rem_res_q;
    reg  [`TACAV_RES_W-1:0] loc_pend_q;
    reg  [`TACAV_RES_W-1:0] rem_pend_q;
    reg                     loc_pend_v_q;
    reg                     rem_pend_v_q;
    reg                     freeze_q;
    reg                     ch_q;
    wire                    avg_done;
    wire [`TACAV_RES_W-1:0] avg_mean;
    wire                    running;
    wire                    rd_ok;
    wire                    take_loc;
    wire                    take_rem;
    wire                    smp_take;
    wire                    last_smp;
    wire                    ch_next;
    wire                    lo_rd;
    reg  [4:0]              smp_n_q;
    reg                     res_ch_q;

    // Halting mid-average drops the partial sum so that a result never mixes
    // samples from before and after a stop.
    assign running  = RUN && (st_q != ST_BOOT);
    assign rd_ok    = RD_STB && READY;
    // A low read blocks an update on its own edge, so that the low byte and
    // the high bytes read after it always come from one result.
    assign lo_rd    = rd_ok && (RD_SEL == `TACAV_RD_LOW);
    assign take_loc = !freeze_q && !lo_rd && loc_pend_v_q;
    assign take_rem = !freeze_q && !lo_rd && rem_pend_v_q;
    assign smp_take = ADC_VALID && (st_q == ST_WAIT);
    // The flip must reach the start that follows the 32nd sample, so the
    // count is mirrored here rather than waiting for the filter's done.
    assign last_smp = running && smp_take && (smp_n_q == 5'h1f);
    assign ch_next  = running ? (last_smp ? ~ch_q : ch_q) : `TACAV_CH_LOCAL;

    function [7:0] tacav_byte;
        input [1:0]              sel;
        input [`TACAV_RES_W-1:0] loc;
        input [`TACAV_RES_W-1:0] rem;
        begin
            case (sel)
                `TACAV_RD_LOW:      tacav_byte = {loc[2:0], 2'b00, rem[2:0]};
                `TACAV_RD_LOC_HIGH: tacav_byte = loc[`TACAV_RES_W-1:`TACAV_LO_W];
                `TACAV_RD_REM_HIGH: tacav_byte = rem[`TACAV_RES_W-1:`TACAV_LO_W];
                default:            tacav_byte = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Averaging filter
    // ----------------------------------------------------------------
    tacav_avg u_avg (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .clear     (!running),
        .smp_valid (smp_take),
        .smp_data  (ADC_DATA),
        .done_q    (avg_done),
        .mean_q    (avg_mean)
    );

    // ----------------------------------------------------------------
    // Sample count, kept in step with the filter
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            smp_n_q <= 5'h00;
        end else if (CE) begin
            if (!running)
                smp_n_q <= 5'h00;
            else if (smp_take)
                smp_n_q <= smp_n_q + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_BOOT: if (por_cnt_q >= POR_CYCLES - 28'h1) st_d = ST_IDLE;
            ST_IDLE: if (running) st_d = ST_REQ;
            ST_REQ:  st_d = ST_WAIT;
            ST_WAIT: begin
                if (!running)
                    st_d = ST_IDLE;
                else if (ADC_VALID)
                    st_d = ST_REQ;
            end
            default: st_d = ST_BOOT;
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer, storage and read port
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q          <= ST_BOOT;
            por_cnt_q     <= 28'h0000000;
            loc_res_q     <= 11'h000;
            rem_res_q     <= 11'h000;
            loc_pend_q    <= 11'h000;
            rem_pend_q    <= 11'h000;
            loc_pend_v_q  <= 1'b0;
            rem_pend_v_q  <= 1'b0;
            freeze_q      <= 1'b0;
            ch_q          <= `TACAV_CH_LOCAL;
            res_ch_q      <= `TACAV_CH_LOCAL;
            ADC_START     <= 1'b0;
            ADC_CHANNEL   <= `TACAV_CH_LOCAL;
            READY         <= 1'b0;
            RD_ACK        <= 1'b0;
            RD_DATA       <= `TACAV_RST_VAL;
            FROZEN        <= 1'b0;
            LOCAL_UPDATE  <= 1'b0;
            REMOTE_UPDATE <= 1'b0;
        end else if (CE) begin
            if (SOFT_RESET) begin
                // Soft reset restarts the boot wait; stored results survive
                st_q         <= ST_BOOT;
                por_cnt_q    <= 28'h0000000;
                READY        <= 1'b0;
                freeze_q     <= 1'b0;
                FROZEN       <= 1'b0;
                ch_q         <= `TACAV_CH_LOCAL;
                loc_pend_v_q <= 1'b0;
                rem_pend_v_q <= 1'b0;
                ADC_START    <= 1'b0;
                RD_ACK       <= 1'b0;
                LOCAL_UPDATE <= 1'b0;
                REMOTE_UPDATE <= 1'b0;
            end else begin
                st_q      <= st_d;
                por_cnt_q <= (st_q == ST_BOOT) ? por_cnt_q + 28'h1 : por_cnt_q;
                READY     <= (st_d != ST_BOOT);
                ADC_START <= (st_d == ST_REQ);
                // Channel flips with the start that follows a 32nd sample
                ADC_CHANNEL <= ch_next;
                ch_q        <= ch_next;
                if (last_smp)
                    res_ch_q <= ch_q;
                // A finished result waits in a pending slot while frozen,
                // so the newest one still lands after the unfreeze.
                if (avg_done && running && res_ch_q == `TACAV_CH_LOCAL) begin
                    loc_pend_q   <= avg_mean;
                    loc_pend_v_q <= 1'b1;
                end else if (take_loc) begin
                    loc_pend_v_q <= 1'b0;
                end
                if (avg_done && running && res_ch_q == `TACAV_CH_REMOTE) begin
                    rem_pend_q   <= avg_mean;
                    rem_pend_v_q <= 1'b1;
                end else if (take_rem) begin
                    rem_pend_v_q <= 1'b0;
                end
                if (take_loc)
                    loc_res_q <= loc_pend_q;
                if (take_rem)
                    rem_res_q <= rem_pend_q;
                LOCAL_UPDATE  <= take_loc;
                REMOTE_UPDATE <= take_rem;
                // Freeze on low byte, release on remote high byte
                if (rd_ok && RD_SEL == `TACAV_RD_LOW)
                    freeze_q <= 1'b1;
                else if (rd_ok && RD_SEL == `TACAV_RD_REM_HIGH)
                    freeze_q <= 1'b0;
                FROZEN <= (rd_ok && RD_SEL == `TACAV_RD_LOW) ? 1'b1 :
                          (rd_ok && RD_SEL == `TACAV_RD_REM_HIGH) ? 1'b0 : freeze_q;
                RD_ACK <= rd_ok;
                if (rd_ok)
                    RD_DATA <= tacav_byte(RD_SEL, loc_res_q, rem_res_q);
            end
        end
    end
endmodule // tacav_top

// file: verification/tacav_adc_model.sv
// Purpose: Behavioural front end that answers each sample request
// Assumes: One request in flight; dly sets the answer latency in cycles
// Notes:   Samples alternate base and base+2, so a true mean is base+1
`timescale 1ns/1ps
module tacav_adc_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic        channel,
    input  wire logic [1:0]  dly,
    input  wire logic [10:0] loc_base,
    input  wire logic [10:0] rem_base,
    output logic             valid,
    output logic      [10:0] data
);
    logic [1:0] cnt_q;
    logic       pend_q;
    logic       ch_q;
    logic       odd_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= 1'b0;
            data <= 11'h2aa;
            pend_q <= 1'b0;
            cnt_q <= 2'h0;
            ch_q <= 1'b0;
            odd_q <= 1'b0;
        end else begin
            valid <= 1'b0;
            // Toggle between samples so a stale value can never look valid
            data <= ~data;
            if (start) begin
                pend_q <= 1'b1;
                cnt_q <= dly;
                ch_q <= channel;
            end else if (pend_q && cnt_q != 2'h0) begin
                cnt_q <= cnt_q - 2'h1;
            end else if (pend_q) begin
                valid <= 1'b1;
                pend_q <= 1'b0;
                odd_q <= ~odd_q;
                data <= (ch_q ? rem_base : loc_base) + {9'h0, odd_q, 1'b0};
            end
        end
    end
endmodule // tacav_adc_model

// file: verification/tacav_top_assertions.sv
// Purpose: Port checks for the averaging control
// Assumes: CE high while checked; one clock domain
// Notes:   Boot time checked within one cycle to allow for soft reset latency
`timescale 1ns/1ps
module tacav_chk #(parameter [27:0] POR_CYCLES = 28'd20) (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic        RUN,
    input wire logic        SOFT_RESET,
    input wire logic        ADC_VALID,
    input wire logic [10:0] ADC_DATA,
    input wire logic        RD_STB,
    input wire logic [1:0]  RD_SEL,
    input wire logic        ADC_START,
    input wire logic        ADC_CHANNEL,
    input wire logic        READY,
    input wire logic        RD_ACK,
    input wire logic [7:0]  RD_DATA,
    input wire logic        FROZEN,
    input wire logic        LOCAL_UPDATE,
    input wire logic        REMOTE_UPDATE
);
    logic [27:0] boot_q;
    wire         rd_ok = RD_STB && READY && CE;
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N || (CE && SOFT_RESET)) boot_q <= 28'h0;
        else if (CE && !READY) boot_q <= boot_q + 28'h1;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_boot; $rose(READY) |-> boot_q + 28'h1 >= POR_CYCLES && boot_q <= POR_CYCLES + 28'h1; endproperty
    a_boot: assert property (p_boot) else $error("ready time wrong");
    property p_ack; rd_ok |=> RD_ACK; endproperty
    a_ack: assert property (p_ack) else $error("read not answered");
    property p_noack; RD_STB && !READY |=> !RD_ACK; endproperty
    a_noack: assert property (p_noack) else $error("read answered in boot");
    property p_cause; RD_ACK |-> $past(rd_ok); endproperty
    a_cause: assert property (p_cause) else $error("stray answer");
    property p_frz; rd_ok && RD_SEL == 2'h0 |=> FROZEN; endproperty
    a_frz: assert property (p_frz) else $error("low read did not freeze");
    property p_thaw; rd_ok && RD_SEL == 2'h2 && FROZEN |=> !FROZEN; endproperty
    a_thaw: assert property (p_thaw) else $error("freeze not released");
    property p_hold; FROZEN |-> !LOCAL_UPDATE && !REMOTE_UPDATE; endproperty
    a_hold: assert property (p_hold) else $error("update while frozen");
    property p_halt; !RUN && !$past(RUN) |-> !ADC_START; endproperty
    a_halt: assert property (p_halt) else $error("sample while halted");
    property p_next; ADC_VALID && RUN && READY && !FROZEN ##1 RUN |-> ##[0:3] ADC_START; endproperty
    a_next: assert property (p_next) else $error("conversion stalled");
    property p_pulse; ADC_START |=> !ADC_START; endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_excl; LOCAL_UPDATE && REMOTE_UPDATE |-> $past(FROZEN, 2); endproperty
    a_excl: assert property (p_excl) else $error("both channels updated");
endmodule // tacav_chk
bind tacav_top tacav_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .CE(CE), .RUN(RUN), .SOFT_RESET(SOFT_RESET), .ADC_VALID(ADC_VALID), .ADC_DATA(ADC_DATA),
    .RD_STB(RD_STB), .RD_SEL(RD_SEL), .ADC_START(ADC_START), .ADC_CHANNEL(ADC_CHANNEL),
    .READY(READY), .RD_ACK(RD_ACK), .RD_DATA(RD_DATA), .FROZEN(FROZEN),
    .LOCAL_UPDATE(LOCAL_UPDATE), .REMOTE_UPDATE(REMOTE_UPDATE));

// file: verification/tacav_top_test.sv
// Purpose: Self-checking bench for the averaging control
// Assumes: Boot wait shortened to 20 cycles
// Notes:   Expected means are base+1 from the model's sample pattern
`timescale 1ns/1ps
module tacav_top_test;
    logic        clk, rst_n, ce, run, srst, stb;
    logic [1:0]  sel, dly;
    logic [10:0] lb, rb, ol, orr;
    wire         vld, st, ch, rdy, ack, frz, lu, ru;
    wire  [10:0] adat;
    wire  [7:0]  rdat;
    int          failures = 0;
    int          checks = 0;
    int          nloc = 0;
    tacav_top #(.POR_CYCLES(28'd20)) dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .RUN(run),
        .SOFT_RESET(srst), .ADC_VALID(vld), .ADC_DATA(adat), .RD_STB(stb), .RD_SEL(sel),
        .ADC_START(st), .ADC_CHANNEL(ch), .READY(rdy), .RD_ACK(ack), .RD_DATA(rdat),
        .FROZEN(frz), .LOCAL_UPDATE(lu), .REMOTE_UPDATE(ru));
    tacav_adc_model u_adc (.clk(clk), .rst_n(rst_n), .start(st), .channel(ch), .dly(dly),
        .loc_base(lb), .rem_base(rb), .valid(vld), .data(adat));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (lu === 1'b1) nloc++;
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wt(input int s, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if ((s == 0 && rdy === 1'b1) || (s == 2 && ru === 1'b1)) return;
        end
        chk("wait", 11'h0, 11'h1);
        results();
    endtask
    task automatic rd(input logic [1:0] s, input logic a, input logic [7:0] e);
        @(posedge clk) begin stb <= 1'b1; sel <= s; end
        @(posedge clk) stb <= 1'b0;
        #1 chk("rd_ack", {10'h0, ack}, {10'h0, a});
        if (a) chk("rd_data", {3'h0, rdat}, {3'h0, e});
    endtask
    // Reads all three bytes of the expected means
    task automatic rd3(input logic [10:0] l, input logic [10:0] r);
        rd(2'h0, 1'b1, {l[2:0], 2'b00, r[2:0]});
        chk("frozen", {10'h0, frz}, 11'h1);
        rd(2'h1, 1'b1, l[10:3]);
        rd(2'h2, 1'b1, r[10:3]);
        chk("thawed", {10'h0, frz}, 11'h0);
    endtask
    task automatic t_boot();
        rd(2'h0, 1'b0, 8'h00);
        wt(0, 40);
        rd(2'h3, 1'b1, 8'h00);
    endtask
    task automatic t_round();
        @(posedge clk) run <= 1'b1;
        wt(2, 2000);
        chk("local_first", nloc[10:0], 11'h1);
        rd3(ol, orr);
    endtask
    task automatic t_freeze();
        rd(2'h0, 1'b1, {ol[2:0], 2'b00, orr[2:0]});
        @(posedge clk) begin lb <= 11'h038; rb <= 11'h4d5; dly <= 2'h3; end
        repeat (900) @(posedge clk);
        rd(2'h1, 1'b1, ol[10:3]);
        rd(2'h2, 1'b1, orr[10:3]);
        wt(2, 3000);
        wt(2, 3000);
        ol = 11'h039;
        orr = 11'h4d6;
        rd3(ol, orr);
    endtask
    task automatic t_halt();
        int n;
        n = 0;
        @(posedge clk) run <= 1'b0;
        repeat (3) @(posedge clk);
        repeat (200) begin
            @(posedge clk);
            #1 if (st === 1'b1) n++;
        end
        chk("halted_starts", n[10:0], 11'h0);
        @(posedge clk) run <= 1'b1;
    endtask
    task automatic t_soft();
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) begin srst <= 1'b0; ce <= 1'b0; end
        repeat (40) @(posedge clk);
        #1 chk("ce_hold", {10'h0, rdy}, 11'h0);
        @(posedge clk) ce <= 1'b1;
        rd(2'h1, 1'b0, 8'h00);
        wt(0, 40);
        rd3(ol, orr);
    endtask
    initial begin
        {rst_n, run, srst, stb, sel, dly} = '0;
        ce = 1'b1;
        lb = 11'h190;
        rb = 11'h7c0;
        ol = 11'h191;
        orr = 11'h7c1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_boot();
        t_round();
        t_freeze();
        t_halt();
        t_soft();
        results();
    end
endmodule // tacav_top_test
